// *** hw/sbsf_pkg.sv ***
/*
 sbsf_pkg: constants, types and register map of the byte serdes framer.
 assumes one system clock that stands for the multiplied line clock; no imports.
*/
// Notes on behaviour
// - tx byte is captured on the rising edge of the byte clock input.
// - each tx byte is serialized most significant bit first.
// - serial tx data changes on the falling edge of the serial tx clock.
// - ratio select and line rate select pick multiplier ratio and line rate.
// - ratio codes 110/010/001/000 give divide 32/16/12/8; rate high means fast line.
// - tx byte clock output is the multiplier clock divided by eight.
// - tx path turns bytes into a serial stream at the selected line rate.
// - loop timing runs the whole part from the received serial clock, except during loss or local loopback.
// - serial rx data is sampled on the rising edge of the rx clock.
// - rx serial becomes bytes with a divide by eight byte clock.
// - frame search repeats as long as the search request is high.
// - frame found on three A1 then three A2 bytes at any bit offset.
// - after a find, rx bytes align starting with the third A2 byte.
// - frame pulse lasts one byte period with the third A2 on the bus.
// - frame pulse only while search request high or just being lowered.
// - loss of signal forces rx byte outputs to zero.
// - during loss, rx section runs from the tx multiplier clock.
// - loss control is the XNOR of the two interchangeable loss inputs.
// - line loopback routes rx data and clock onto the serial tx outputs.
// - in line loopback rx still deserializes with byte clock from rx clock.
// - local loopback feeds the tx serial stream into the deserializer.
// - in local loopback the rx byte clock comes from the multiplier clock.
// - in local loopback serial tx outputs keep carrying tx data and clock.
// - both loopbacks together act each as alone, crossing no path.
package sbsf_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FRAMES = 8'h08;
    localparam logic [7:0] A1_BYTE = 8'hF6;
    localparam logic [7:0] A2_BYTE = 8'h28;
    localparam logic [47:0] FRAME_PAT = {A1_BYTE, A1_BYTE, A1_BYTE, A2_BYTE, A2_BYTE, A2_BYTE};
    localparam logic [2:0] RATIO_19M = 3'h6;
    localparam logic [2:0] RATIO_38M = 3'h2;
    localparam logic [2:0] RATIO_51M = 3'h1;
    localparam logic [2:0] RATIO_77M = 3'h0;
    localparam logic [5:0] DIV_19M = 6'h20;
    localparam logic [5:0] DIV_38M = 6'h10;
    localparam logic [5:0] DIV_51M = 6'h0C;
    localparam logic [5:0] DIV_77M = 6'h08;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_HALF = 3'h3;
    localparam int STS3_MULT = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic rx_clock_timing_sel;
        logic local_loopback_en;
        logic line_loopback_en;
        logic [2:0] ref_ratio_sel;
        logic line_rate_sel;
    } sbsf_ctrl_t;

    localparam sbsf_ctrl_t CTRL_RESET = '0;

    typedef enum logic [1:0] {
        FRM_IDLE = 2'b00,
        FRM_HUNT = 2'b01,
        FRM_SYNC = 2'b10
    } sbsf_frm_t;

    typedef struct packed {
        logic [5:0] divide;
        logic bad_ratio;
        sbsf_frm_t frm;
        logic lost;
    } sbsf_status_t;
endpackage

// *** hw/sbsf_top.sv ***
/*
 sbsf_top: serializer, deserializer, A1/A2 framer, loss and loopback steering.
 assumes serial and byte pins synchronous to sys_clk; config over AXI4-Lite.
*/
`timescale 1ns/100ps
module sbsf_top #(
    parameter int BIT_DIV = 2,
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_byte_clk_in,
    output logic tx_byte_clk_out,
    output logic ser_tx_out,
    output logic ser_tx_clk_out,
    input wire logic ser_rx_in,
    input wire logic ser_rx_clk_in,
    output logic [7:0] rx_byte_out,
    output logic rx_byte_clk_out,
    output logic frame_pulse,
    input wire logic frame_search_req,
    input wire logic loss_in_a,
    input wire logic loss_in_b,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [7:0] FAST_PERIOD = 8'(BIT_DIV);
    localparam logic [7:0] SLOW_PERIOD = 8'(BIT_DIV * sbsf_pkg::STS3_MULT);

    logic rst_s1_reg;
    logic rst_n_reg;
    sbsf_pkg::sbsf_ctrl_t ctrl_reg;
    logic signal_lost_reg;
    logic [7:0] div_cnt_reg;
    logic int_clk_reg;
    logic rx_d_reg;
    logic rx_clk_reg;
    logic rx_clk_p_reg;
    logic tx_bclk_p_reg;
    logic [7:0] tx_hold_reg;
    logic [7:0] tx_sh_reg;
    logic [2:0] tx_cnt_reg;
    logic tx_ser_bit_reg;
    logic [47:0] rx_sr_reg;
    logic [2:0] rx_cnt_reg;
    logic oof_p_reg;
    sbsf_pkg::sbsf_frm_t frm_reg;
    logic [15:0] frames_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    logic [7:0] period;
    logic int_rise;
    logic int_fall;
    logic rx_rise;
    logic rx_fall;
    logic tx_rise;
    logic tx_fall;
    logic rx_ev;
    logic rx_bit;
    logic [47:0] rx_sr_next;
    logic search_en;
    logic frame_hit;
    logic [5:0] divide;
    logic bad_ratio;
    sbsf_pkg::sbsf_status_t status;

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    // ratio decode, reported in status
    always_comb begin
        bad_ratio = 1'b0;
        case (ctrl_reg.ref_ratio_sel)
            sbsf_pkg::RATIO_19M: divide = sbsf_pkg::DIV_19M;
            sbsf_pkg::RATIO_38M: divide = sbsf_pkg::DIV_38M;
            sbsf_pkg::RATIO_51M: divide = sbsf_pkg::DIV_51M;
            sbsf_pkg::RATIO_77M: divide = sbsf_pkg::DIV_77M;
            default: begin
                divide = sbsf_pkg::DIV_77M;
                bad_ratio = 1'b1;
            end
        endcase
    end

    // multiplier clock model: bit period set by line rate
    assign period = ctrl_reg.line_rate_sel ? FAST_PERIOD : SLOW_PERIOD;
    assign int_rise = (div_cnt_reg == 8'h00);
    assign int_fall = (div_cnt_reg == (period >> 1));

    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            div_cnt_reg <= 8'h00;
            int_clk_reg <= 1'b0;
        end else begin
            div_cnt_reg <= (div_cnt_reg >= period - 8'h01) ? 8'h00 : div_cnt_reg + 8'h01;
            if (int_rise)
                int_clk_reg <= 1'b1;
            else if (int_fall)
                int_clk_reg <= 1'b0;
        end
    end

    // serial rx pins sampled, edges of rx clock
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rx_d_reg <= 1'b0;
            rx_clk_reg <= 1'b0;
            rx_clk_p_reg <= 1'b0;
            oof_p_reg <= 1'b0;
            signal_lost_reg <= 1'b0;
        end else begin
            rx_d_reg <= ser_rx_in;
            rx_clk_reg <= ser_rx_clk_in;
            rx_clk_p_reg <= rx_clk_reg;
            oof_p_reg <= frame_search_req;
            signal_lost_reg <= ~(loss_in_a ^ loss_in_b);
        end
    end

    assign rx_rise = rx_clk_reg && !rx_clk_p_reg;
    assign rx_fall = !rx_clk_reg && rx_clk_p_reg;
    // loop timing: tx runs from rx clock unless lost or in local loopback
    assign tx_rise = (ctrl_reg.rx_clock_timing_sel && !signal_lost_reg && !ctrl_reg.local_loopback_en)
                     ? rx_rise : int_rise;
    assign tx_fall = (ctrl_reg.rx_clock_timing_sel && !signal_lost_reg && !ctrl_reg.local_loopback_en)
                     ? rx_fall : int_fall;

    // tx byte capture and serializer
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tx_bclk_p_reg <= 1'b0;
            tx_hold_reg <= 8'h00;
        end else begin
            tx_bclk_p_reg <= tx_byte_clk_in;
            if (tx_byte_clk_in && !tx_bclk_p_reg)
                tx_hold_reg <= tx_byte_in;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tx_sh_reg <= 8'h00;
            tx_cnt_reg <= 3'h0;
            tx_ser_bit_reg <= 1'b0;
            tx_byte_clk_out <= 1'b0;
        end else if (tx_fall) begin
            tx_cnt_reg <= tx_cnt_reg + 3'h1;
            if (tx_cnt_reg == 3'h0) begin
                tx_ser_bit_reg <= tx_hold_reg[7];
                tx_sh_reg <= {tx_hold_reg[6:0], 1'b0};
                tx_byte_clk_out <= 1'b1;
            end else begin
                tx_ser_bit_reg <= tx_sh_reg[7];
                tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                if (tx_cnt_reg == sbsf_pkg::BIT_HALF + 3'h1)
                    tx_byte_clk_out <= 1'b0;
            end
        end
    end

    // serial tx pins: line loopback takes rx data and clock
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ser_tx_out <= 1'b0;
            ser_tx_clk_out <= 1'b0;
        end else if (ctrl_reg.line_loopback_en) begin
            ser_tx_out <= rx_d_reg;
            ser_tx_clk_out <= rx_clk_reg;
        end else begin
            ser_tx_out <= tx_ser_bit_reg;
            ser_tx_clk_out <= (ctrl_reg.rx_clock_timing_sel && !signal_lost_reg && !ctrl_reg.local_loopback_en)
                              ? rx_clk_reg : int_clk_reg;
        end
    end

    // rx source steering
    assign rx_ev = (signal_lost_reg || ctrl_reg.local_loopback_en) ? tx_rise : rx_rise;
    assign rx_bit = signal_lost_reg ? 1'b0 :
                    ctrl_reg.local_loopback_en ? tx_ser_bit_reg : rx_d_reg;
    assign rx_sr_next = {rx_sr_reg[46:0], rx_bit};
    assign search_en = frame_search_req || oof_p_reg;
    assign frame_hit = rx_ev && search_en && !signal_lost_reg && (rx_sr_next == sbsf_pkg::FRAME_PAT);

    // deserializer, byte alignment and frame pulse
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rx_sr_reg <= '0;
            rx_cnt_reg <= 3'h0;
            rx_byte_out <= 8'h00;
            rx_byte_clk_out <= 1'b0;
            frame_pulse <= 1'b0;
        end else begin
            if (rx_ev) begin
                rx_sr_reg <= rx_sr_next;
                if (frame_hit) begin
                    rx_cnt_reg <= 3'h0;
                    rx_byte_out <= rx_sr_next[7:0];
                    rx_byte_clk_out <= 1'b1;
                    frame_pulse <= 1'b1;
                end else if (rx_cnt_reg == sbsf_pkg::BIT_LAST) begin
                    rx_cnt_reg <= 3'h0;
                    rx_byte_out <= rx_sr_next[7:0];
                    rx_byte_clk_out <= 1'b1;
                    frame_pulse <= 1'b0;
                end else begin
                    rx_cnt_reg <= rx_cnt_reg + 3'h1;
                    if (rx_cnt_reg == sbsf_pkg::BIT_HALF)
                        rx_byte_clk_out <= 1'b0;
                end
            end
            if (signal_lost_reg)
                rx_byte_out <= 8'h00;
        end
    end

    // frame state and count
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            frm_reg <= sbsf_pkg::FRM_IDLE;
            frames_reg <= 16'h0000;
        end else begin
            if (frame_hit)
                frames_reg <= frames_reg + 16'h0001;
            case (frm_reg)
                sbsf_pkg::FRM_IDLE: begin
                    if (frame_hit)
                        frm_reg <= sbsf_pkg::FRM_SYNC;
                    else if (frame_search_req)
                        frm_reg <= sbsf_pkg::FRM_HUNT;
                end
                sbsf_pkg::FRM_HUNT: begin
                    if (frame_hit)
                        frm_reg <= sbsf_pkg::FRM_SYNC;
                    else if (!search_en)
                        frm_reg <= sbsf_pkg::FRM_IDLE;
                end
                sbsf_pkg::FRM_SYNC: begin
                    if (frame_search_req && !oof_p_reg)
                        frm_reg <= sbsf_pkg::FRM_HUNT;
                end
                default: frm_reg <= sbsf_pkg::FRM_IDLE;
            endcase
        end
    end

    assign status = '{divide: divide, bad_ratio: bad_ratio, frm: frm_reg, lost: signal_lost_reg};

    // AXI4-Lite write
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sbsf_pkg::RESP_OKAY;
            ctrl_reg <= sbsf_pkg::CTRL_RESET;
        end else begin
            s_axi_awready <= !aw_got_reg && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_got_reg && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (aw_got_reg && w_got_reg && !s_axi_bvalid) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_reg == ADDR_W'(sbsf_pkg::OFS_CTRL)) begin
                    s_axi_bresp <= sbsf_pkg::RESP_OKAY;
                    if (w_strb_reg[0])
                        ctrl_reg <= w_data_reg[$bits(sbsf_pkg::sbsf_ctrl_t)-1:0];
                end else begin
                    s_axi_bresp <= sbsf_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= sbsf_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= sbsf_pkg::RESP_OKAY;
                case (s_axi_araddr)
                    ADDR_W'(sbsf_pkg::OFS_CTRL): s_axi_rdata <= 32'(ctrl_reg);
                    ADDR_W'(sbsf_pkg::OFS_STATUS): s_axi_rdata <= 32'(status);
                    ADDR_W'(sbsf_pkg::OFS_FRAMES): s_axi_rdata <= {16'h0000, frames_reg};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= sbsf_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n_reg);

    loss_xnor_a: assert property (signal_lost_reg == $past(~(loss_in_a ^ loss_in_b)))
        else $error("loss control not xnor of inputs");
    loss_zero_a: assert property (signal_lost_reg |=> rx_byte_out == 8'h00)
        else $error("rx bytes not zero in loss");
    pulse_search_a: assert property ($rose(frame_pulse) |-> $past(search_en))
        else $error("frame pulse without search");
    pulse_a2_a: assert property ($rose(frame_pulse) |-> rx_byte_out == sbsf_pkg::A2_BYTE)
        else $error("frame pulse not on third A2");
    pulse_width_a: assert property ($fell(frame_pulse) |-> $past(rx_ev) && $rose(rx_byte_clk_out))
        else $error("frame pulse not one byte period");
    tx_capture_a: assert property ((tx_byte_clk_in && !tx_bclk_p_reg) |=> tx_hold_reg == $past(tx_byte_in))
        else $error("tx byte not captured on rising edge");
    msb_first_a: assert property ((tx_fall && tx_cnt_reg == 3'h0) |=> tx_ser_bit_reg == $past(tx_hold_reg[7]))
        else $error("serial byte not msb first");
    tx_edge_a: assert property ($changed(tx_ser_bit_reg) |-> $past(tx_fall))
        else $error("serial data changed off falling edge");
    line_loop_a: assert property ($past(ctrl_reg.line_loopback_en) && ctrl_reg.line_loopback_en
                                  |-> ser_tx_out == $past(rx_d_reg) && ser_tx_clk_out == $past(rx_clk_reg))
        else $error("line loopback not steering rx to tx");
    bclk_div_a: assert property ($rose(tx_byte_clk_out) |-> $past(tx_fall) && $past(tx_cnt_reg) == 3'h0)
        else $error("tx byte clock not divide by eight");

    frame_found_c: cover property (frame_hit && !ctrl_reg.local_loopback_en);
    local_frame_c: cover property (frame_hit && ctrl_reg.local_loopback_en);
    loss_c: cover property ($rose(signal_lost_reg));
    split_loop_c: cover property (ctrl_reg.line_loopback_en && ctrl_reg.local_loopback_en && rx_ev);
endmodule

// *** testbench/sbsf_uni_model.sv ***
/*
 sbsf_uni_model: byte-side transmit partner of the byte serdes framer.
 assumes the sys_clk domain; the bench queues bytes through push.
*/
`timescale 1ns/100ps
module sbsf_uni_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic tx_byte_clk_out,
    output logic [7:0] tx_byte_in,
    output logic tx_byte_clk_in
);
    logic [7:0] q[$];
    logic [2:0] clk_pipe;

    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask

    initial begin
        tx_byte_in = 8'h00;
        clk_pipe = 3'h0;
    end

    // byte set after the clock rise, own clock returned late
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            clk_pipe <= 3'h0;
            tx_byte_in <= 8'h00;
        end else begin
            clk_pipe <= {clk_pipe[1:0], tx_byte_clk_out};
            if (clk_pipe[0] && !clk_pipe[1]) begin
                tx_byte_in <= (q.size() > 0) ? q.pop_front() : 8'h00;
            end
        end
    end

    assign tx_byte_clk_in = clk_pipe[2];
endmodule

// *** testbench/sbsf_top_tb.sv ***
/*
 sbsf_top_tb: self-checking bench for the byte serdes framer.
 assumes sbsf_top with AXI4-Lite config and the uni partner model.
*/
`timescale 1ns/100ps
module sbsf_top_tb;
    logic sys_clk = 1'h0;
    logic nrst = 1'h0;
    logic [7:0] tx_byte_in, rx_byte_out;
    logic tx_byte_clk_in, tx_byte_clk_out, ser_tx_out, ser_tx_clk_out, rx_byte_clk_out, frame_pulse;
    logic ser_rx_in = 1'h0;
    logic ser_rx_clk_in = 1'h0;
    logic frame_search_req = 1'h0;
    logic loss_in_a = 1'h0;
    logic loss_in_b = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, prev, prev2;
    logic [47:0] tx_sr = '0;
    logic tx_clk_p = 1'h0;
    logic tx_pat_seen = 1'h0;
    logic [31:0] s_axi_rdata, rd;
    logic [63:0] v;
    logic [2:0] codes[4] = '{3'h6, 3'h2, 3'h1, 3'h0};
    logic [5:0] divs[4] = '{6'h20, 6'h10, 6'h0C, 6'h08};
    int num_errors = 0;
    int checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    sbsf_top dut (.sys_clk, .nrst, .tx_byte_in, .tx_byte_clk_in, .tx_byte_clk_out, .ser_tx_out, .ser_tx_clk_out,
        .ser_rx_in, .ser_rx_clk_in, .rx_byte_out, .rx_byte_clk_out, .frame_pulse, .frame_search_req, .loss_in_a,
        .loss_in_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    sbsf_uni_model uni (.sys_clk, .nrst, .tx_byte_clk_out, .tx_byte_in, .tx_byte_clk_in);

    // serial tx stream taken at the rise of its clock
    always @(posedge sys_clk) begin
        tx_clk_p <= ser_tx_clk_out;
        if (ser_tx_clk_out === 1'h1 && tx_clk_p === 1'h0) tx_sr <= {tx_sr[46:0], ser_tx_out};
        if (tx_sr === 48'hF6F6F6282828) tx_pat_seen <= 1'h1;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // one serial bit, data steady across the rx clock rise
    task automatic send_bit(input logic b);
        @(posedge sys_clk);
        ser_rx_in <= b;
        ser_rx_clk_in <= 1'h0;
        repeat (2) @(posedge sys_clk);
        ser_rx_clk_in <= 1'h1;
        @(posedge sys_clk);
    endtask

    task automatic send_rx(input int off, input logic [63:0] pat);
        for (int i = 0; i < off; i++) send_bit(1'($urandom));
        for (int i = 63; i >= 0; i--) send_bit(pat[i]);
        @(posedge sys_clk);
        ser_rx_clk_in <= 1'h0;
        ser_rx_in <= ~ser_rx_in;
    endtask

    task automatic watch(input logic exp_hit, input logic [7:0] nxt, input int lim);
        int hits;
        hits = 0;
        for (int n = 0; n < lim; n++) begin
            @(posedge sys_clk);
            if (frame_pulse === 1'h1) begin
                hits++;
                if (hits == 1) begin
                    chk("aligned byte", 8'h28, rx_byte_out);
                    while (frame_pulse === 1'h1) @(posedge sys_clk);
                    chk("next byte", nxt, rx_byte_out);
                    chk("byte clock", 1'h1, rx_byte_clk_out);
                end
            end
        end
        chk("frame found", exp_hit, hits != 0);
    endtask

    task automatic rx_frame(input logic exp_hit);
        v = {48'hF6F6F6282828, 8'($urandom), 8'($urandom)};
        fork
            send_rx($urandom_range(0, 7), v);
            watch(exp_hit, v[15:8], 400);
        join
    endtask

    task automatic finish_test();
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge sys_clk);
        num_errors++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h646d));
        repeat (4) @(posedge sys_clk);
        nrst <= 1'h1;
        repeat (4) @(posedge sys_clk);
        axi_rd(8'h00, rd, rsp);
        chk("ctrl reset", 32'h0, rd);
        for (int i = 0; i < 4; i++) begin
            axi_wr(8'h00, {28'h0, codes[i], 1'h1}, rsp);
            axi_rd(8'h00, rd, rsp);
            chk("ctrl", {28'h0, codes[i], 1'h1}, rd);
            axi_rd(8'h04, rd, rsp);
            chk("divide", {divs[i], 1'h0}, rd[9:3]);
        end
        axi_rd(8'h0C, rd, rsp);
        chk("unmapped resp", 32'h2, {30'h0, rsp});
        chk("unmapped data", 32'h0, rd);
        for (int i = 0; i < 4; i++) begin
            loss_in_a <= i[1];
            loss_in_b <= i[0];
            repeat (4) @(posedge sys_clk);
            axi_rd(8'h04, rd, rsp);
            chk("loss state", !(i[1] ^ i[0]), rd[0]);
        end
        frame_search_req <= 1'h1;
        rx_frame(1'h0);
        chk("lost rx byte", 8'h00, rx_byte_out);
        loss_in_a <= 1'h0;
        loss_in_b <= 1'h1;
        repeat (2) rx_frame(1'h1);
        axi_rd(8'h08, rd, rsp);
        chk("frame count", 32'h2, rd);
        axi_rd(8'h04, rd, rsp);
        chk("frame state", 32'h2, {30'h0, rd[2:1]});
        frame_search_req <= 1'h0;
        rx_frame(1'h0);
        axi_wr(8'h00, 32'h11, rsp);
        prev = {ser_rx_in, ser_rx_clk_in};
        prev2 = prev;
        repeat (24) begin
            @(posedge sys_clk);
            chk("line loop", prev2, {ser_tx_out, ser_tx_clk_out});
            prev2 = prev;
            prev = {ser_rx_in, ser_rx_clk_in};
            {ser_rx_in, ser_rx_clk_in} <= 2'($urandom);
        end
        @(posedge sys_clk);
        ser_rx_clk_in <= 1'h0;
        frame_search_req <= 1'h1;
        for (int r = 1; r >= 0; r--) begin
            axi_wr(8'h00, {26'h0, 1'h1, 4'h0, 1'(r)}, rsp);
            v = {48'hF6F6F6282828, 8'($urandom), 8'($urandom)};
            for (int i = 7; i >= 0; i--) uni.push(v[i*8+:8]);
            watch(1'h1, v[15:8], 1200);
        end
        chk("serial tx pattern", 1'h1, tx_pat_seen);
        finish_test();
    end
endmodule
